// ===== rtl/fcfc_top.sv
// Fax control frame codec: frame builder, parser, call sequencer and register slave.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fcfc_top import fcfc_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int BIT_CYCLES = FCFC_BIT_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RX_BIT,
	input wire logic RX_BIT_STB,
	input wire logic RX_FRAME_END,
	input wire logic TRAIN_DONE,
	input wire logic TCF_STB,
	input wire logic TCF_OK,
	input wire logic IMAGE_DONE,
	output logic [10:0] TX_TONE_HZ,
	output logic TX_ACTIVE,
	output logic TONE_CNG,
	output logic TONE_CED,
	output logic TRAIN_REQ,
	output logic IMAGE_PHASE,
	output logic IRQ
);
	fcfc_state_t state_reg, state_next;
	fcfc_cap_t local_reg, dis_reg, dcs_reg, rx_cap;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rd_val;
	logic [3:0] wstrb_reg;
	logic aw_full_reg, w_full_reg, wr_fire, rd_ok;
	logic start_reg, answer_reg, ready_reg;
	logic [FCFC_S_BITS-1:0] status_reg, mask_reg, st_set, st_clr;
	logic [FCFC_FRAME_BITS-1:0] rx_sh_reg, tx_data;
	logic [4:0] rx_cnt_reg, tx_len;
	logic [7:0] rx_id;
	logic [2:0] rx_kind, kind_reg;
	logic rx_bad, kind_stb_reg, sent_reg, tx_load_reg, tx_done, send_st;

	// The decoder reads the low eight address bits, so a narrower bus cannot be served.
	if (ADDR_W < 8) begin : g_chk
		$error("fcfc_top: ADDR_W must be at least 8");
	end

	// Byte-enable merge used by the limit register; the other writable registers take byte 0 only.
	function automatic logic [31:0] fcfc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : fcfc_merge

	// Address match on all of the low eight bits, byte-lane bits included.
	function automatic logic fcfc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a[7:0] == off;
	endfunction : fcfc_hit

	// Picks the command mode from the far capabilities and our own limits.
	function automatic fcfc_cap_t fcfc_sel_dcs(input fcfc_cap_t dis, input fcfc_cap_t lim);
		fcfc_cap_t d;
		d = '0;
		d.t4_rx = 1'b1;
		if (dis.rate[1] && lim.rate[1]) begin
			d.rate = FCFC_RATE_9600;
		end else if (dis.rate[0] && lim.rate[0]) begin
			d.rate = FCFC_RATE_4800;
		end else begin
			d.rate = FCFC_RATE_2400;
		end
		if (dis.width == FCFC_W_2432 && lim.width == FCFC_W_2432) begin
			d.width = FCFC_W_2432;
		end else if ((^dis.width) && (^lim.width)) begin
			d.width = FCFC_W_2048;
		end else begin
			d.width = FCFC_W_1728;
		end
		if (dis.length == FCFC_L_UNL && lim.length == FCFC_L_UNL) begin
			d.length = FCFC_L_UNL;
		end else if (dis.length == FCFC_L_B4 && (^lim.length)) begin
			d.length = FCFC_L_B4;
		end else begin
			d.length = FCFC_L_A4;
		end
		d.fine = dis.fine & lim.fine;
		d.twod = dis.twod & lim.twod;
		return d;
	endfunction : fcfc_sel_dcs

	// Write address and data are caught separately; the write lands once both are held.
	assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID;
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= FCFC_RESP_OK;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				awaddr_reg <= S_AXI_AWADDR;
				aw_full_reg <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
				w_full_reg <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (fcfc_hit(awaddr_reg, FCFC_A_CTRL) || fcfc_hit(awaddr_reg, FCFC_A_LOCAL) ||
					fcfc_hit(awaddr_reg, FCFC_A_STATUS) || fcfc_hit(awaddr_reg, FCFC_A_MASK)) ?
					FCFC_RESP_OK : FCFC_RESP_ERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// Control and limit registers; start is a one-cycle pulse out of a write.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			start_reg <= 1'b0;
			answer_reg <= 1'b0;
			ready_reg <= 1'b0;
			local_reg <= '0;
			mask_reg <= '0;
		end else begin
			start_reg <= wr_fire && fcfc_hit(awaddr_reg, FCFC_A_CTRL) && wstrb_reg[0] && wdata_reg[FCFC_C_START];
			if (wr_fire && fcfc_hit(awaddr_reg, FCFC_A_CTRL) && wstrb_reg[0]) begin
				answer_reg <= wdata_reg[FCFC_C_ANSWER];
				ready_reg <= wdata_reg[FCFC_C_READY];
			end
			if (wr_fire && fcfc_hit(awaddr_reg, FCFC_A_LOCAL)) begin
				local_reg <= FCFC_CAP_BITS'(fcfc_merge(32'(local_reg), wdata_reg, wstrb_reg));
			end
			if (wr_fire && fcfc_hit(awaddr_reg, FCFC_A_MASK) && wstrb_reg[0]) begin
				mask_reg <= wdata_reg[FCFC_S_BITS-1:0];
			end
		end
	end

	// Read mux; unmapped offsets read zero with an error response.
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		case (S_AXI_ARADDR[7:0])
			FCFC_A_CTRL: rd_val = 32'({ready_reg, answer_reg, 1'b0});
			FCFC_A_LOCAL: rd_val = 32'(local_reg);
			FCFC_A_STATUS: rd_val = 32'(status_reg);
			FCFC_A_MASK: rd_val = 32'(mask_reg);
			FCFC_A_DIS: rd_val = 32'(dis_reg);
			FCFC_A_DCS: rd_val = 32'(dcs_reg);
			FCFC_A_PHASE: rd_val = 32'(state_reg);
			default: rd_ok = 1'b0;
		endcase
	end

	// One read at a time: the address is taken, the data answers on the next edge.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= FCFC_RESP_OK;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_val;
			S_AXI_RRESP <= rd_ok ? FCFC_RESP_OK : FCFC_RESP_ERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// Received bits collect first-in at the top; a frame ends on its own strobe.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_sh_reg <= '0;
			rx_cnt_reg <= '0;
		end else if (RX_FRAME_END) begin
			rx_cnt_reg <= '0;
		end else if (RX_BIT_STB && rx_cnt_reg != 5'h1F) begin
			rx_sh_reg <= {rx_sh_reg[FCFC_FRAME_BITS-2:0], RX_BIT};
			rx_cnt_reg <= rx_cnt_reg + 1'b1;
		end
	end

	// Frame classification; anything off-shape or with a forbidden code is refused.
	always_comb begin
		rx_kind = 3'h0;
		rx_bad = 1'b0;
		rx_id = (rx_cnt_reg == FCFC_LEN_FULL) ? rx_sh_reg[FCFC_FRAME_BITS-1 -: 8] : rx_sh_reg[7:0];
		rx_cap = fcfc_cap_t'(rx_sh_reg[FCFC_CAP_BITS-1:0]);
		if (rx_cnt_reg == FCFC_LEN_FULL) begin
			if (rx_id == FCFC_ID_DIS) begin
				rx_kind = FCFC_K_DIS;
			end else if ((rx_id & FCFC_ID_DCS_MASK) == FCFC_ID_DCS) begin
				rx_kind = FCFC_K_DCS;
			end else begin
				rx_bad = 1'b1;
			end
			if (rx_cap.width == FCFC_CODE_BAD || rx_cap.length == FCFC_CODE_BAD) begin
				rx_bad = 1'b1;
			end
		end else if (rx_cnt_reg == FCFC_LEN_ID) begin
			case (rx_id)
				FCFC_ID_CFR: rx_kind = FCFC_K_CFR;
				FCFC_ID_MCF: rx_kind = FCFC_K_MCF;
				FCFC_ID_EOP: rx_kind = FCFC_K_EOP;
				FCFC_ID_DCN: rx_kind = FCFC_K_DCN;
				default: rx_bad = 1'b1;
			endcase
		end else begin
			rx_bad = 1'b1;
		end
	end

	// A good DIS is kept, and the command mode is chosen from it at once.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			kind_reg <= 3'h0;
			kind_stb_reg <= 1'b0;
			dis_reg <= '0;
			dcs_reg <= '0;
		end else begin
			kind_stb_reg <= RX_FRAME_END && !rx_bad;
			kind_reg <= rx_kind;
			if (RX_FRAME_END && !rx_bad && rx_kind == FCFC_K_DIS) begin
				dis_reg <= rx_cap;
				dcs_reg <= fcfc_sel_dcs(rx_cap, local_reg);
			end
		end
	end

	// Call sequencer; frames that do not fit the phase are ignored.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (start_reg) state_next = answer_reg ? ST_A_SEND_DIS : ST_C_WAIT_DIS;
			ST_C_WAIT_DIS: if (kind_stb_reg && kind_reg == FCFC_K_DIS) state_next = ST_C_SEND_DCS;
			ST_C_SEND_DCS: if (tx_done) state_next = ST_C_TRAIN;
			ST_C_TRAIN: if (TRAIN_DONE) state_next = ST_C_WAIT_CFR;
			ST_C_WAIT_CFR: if (kind_stb_reg && kind_reg == FCFC_K_CFR) state_next = ST_C_IMAGE;
			ST_C_IMAGE: if (IMAGE_DONE) state_next = ST_C_SEND_EOP;
			ST_C_SEND_EOP: if (tx_done) state_next = ST_C_WAIT_MCF;
			ST_C_WAIT_MCF: if (kind_stb_reg && kind_reg == FCFC_K_MCF) state_next = ST_C_SEND_DCN;
			ST_C_SEND_DCN: if (tx_done) state_next = ST_IDLE;
			ST_A_SEND_DIS: if (tx_done) state_next = ST_A_WAIT_DCS;
			ST_A_WAIT_DCS: if (kind_stb_reg && kind_reg == FCFC_K_DCS) state_next = ST_A_WAIT_TCF;
			ST_A_WAIT_TCF: if (TCF_STB) state_next = (TCF_OK && ready_reg) ? ST_A_SEND_CFR : ST_IDLE;
			ST_A_SEND_CFR: if (tx_done) state_next = ST_A_WAIT_EOP;
			ST_A_WAIT_EOP: if (kind_stb_reg && kind_reg == FCFC_K_EOP) state_next = ST_A_SEND_MCF;
			ST_A_SEND_MCF: if (tx_done) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Frame to send in each sending phase; plain signals carry the code alone.
	always_comb begin
		send_st = 1'b1;
		tx_len = FCFC_LEN_ID;
		tx_data = '0;
		case (state_reg)
			ST_A_SEND_DIS: begin
				tx_data = {FCFC_ID_DIS, local_reg};
				tx_len = FCFC_LEN_FULL;
			end
			ST_C_SEND_DCS: begin
				tx_data = {FCFC_ID_DCS, dcs_reg};
				tx_len = FCFC_LEN_FULL;
			end
			ST_A_SEND_CFR: tx_data = {FCFC_ID_CFR, 20'h0_0000};
			ST_C_SEND_EOP: tx_data = {FCFC_ID_EOP, 20'h0_0000};
			ST_A_SEND_MCF: tx_data = {FCFC_ID_MCF, 20'h0_0000};
			ST_C_SEND_DCN: tx_data = {FCFC_ID_DCN, 20'h0_0000};
			default: send_st = 1'b0;
		endcase
	end

	// One load per sending phase; the flag drops when the phase moves on.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sent_reg <= 1'b0;
			tx_load_reg <= 1'b0;
		end else begin
			tx_load_reg <= send_st && !sent_reg && !tx_load_reg;
			if (state_next != state_reg) begin
				sent_reg <= 1'b0;
			end else if (tx_load_reg) begin
				sent_reg <= 1'b1;
			end
		end
	end

	fcfc_fsk_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.load(tx_load_reg),
		.data(tx_data),
		.nbits(tx_len),
		.tone_hz(TX_TONE_HZ),
		.active(TX_ACTIVE),
		.done(tx_done)
	);

	// Line-side levels follow the phase one cycle late (CED only the first cycle of DIS sending), which keeps them glitch free.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			TONE_CNG <= 1'b0;
			TONE_CED <= 1'b0;
			TRAIN_REQ <= 1'b0;
			IMAGE_PHASE <= 1'b0;
		end else begin
			TONE_CNG <= state_reg == ST_C_WAIT_DIS;
			TONE_CED <= state_reg == ST_A_SEND_DIS && !sent_reg && !tx_load_reg;
			TRAIN_REQ <= state_reg == ST_C_TRAIN;
			IMAGE_PHASE <= state_reg == ST_C_IMAGE || state_reg == ST_A_WAIT_EOP;
		end
	end

	// Sticky status: an event in the clearing cycle wins over the clear.
	always_comb begin
		st_set = '0;
		st_set[FCFC_S_RX] = kind_stb_reg;
		st_set[FCFC_S_ERR] = RX_FRAME_END && rx_bad;
		st_set[FCFC_S_DONE] = tx_done && (state_reg == ST_C_SEND_DCN || state_reg == ST_A_SEND_MCF);
		st_set[FCFC_S_TCF] = state_reg == ST_A_WAIT_TCF && TCF_STB && !(TCF_OK && ready_reg);
		st_clr = (wr_fire && fcfc_hit(awaddr_reg, FCFC_A_STATUS) && wstrb_reg[0]) ?
			wdata_reg[FCFC_S_BITS-1:0] : '0;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			status_reg <= '0;
			IRQ <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~st_clr) | st_set;
			IRQ <= |(((status_reg & ~st_clr) | st_set) & mask_reg);
		end
	end

	dis_frame_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		tx_load_reg && state_reg == ST_A_SEND_DIS |-> tx_data == {FCFC_ID_DIS, local_reg} && tx_len == FCFC_LEN_FULL)
		else $error("DIS load carries wrong code or fields");
	dcs_frame_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		tx_load_reg && state_reg == ST_C_SEND_DCS |-> (tx_data[27:20] & FCFC_ID_DCS_MASK) == FCFC_ID_DCS)
		else $error("DCS load carries wrong code");
	short_frame_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		tx_load_reg && tx_len != FCFC_LEN_FULL |-> tx_data[19:0] == 20'h0_0000 && tx_len == FCFC_LEN_ID)
		else $error("plain signal with appended bits");
	dcs_order_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		$changed(state_reg) && state_reg == ST_C_SEND_DCS |-> $past(state_reg) == ST_C_WAIT_DIS)
		else $error("DCS phase entered out of order");
	cfr_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		$changed(state_reg) && state_reg == ST_A_SEND_CFR |-> $past(TCF_STB) && $past(TCF_OK) && $past(ready_reg))
		else $error("CFR without good training check");
	dcs_limit_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		(dcs_reg.rate != FCFC_RATE_9600 || dis_reg.rate[1]) && (dcs_reg.rate != FCFC_RATE_4800 || dis_reg.rate[0]) &&
		(dcs_reg.width != FCFC_W_2432 || dis_reg.width == FCFC_W_2432) &&
		(dcs_reg.length != FCFC_L_UNL || dis_reg.length == FCFC_L_UNL) && (!dcs_reg.fine || dis_reg.fine))
		else $error("chosen mode beyond far capabilities");
	bad_code_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		RX_FRAME_END && rx_cnt_reg == FCFC_LEN_FULL && rx_cap.width == FCFC_CODE_BAD |=> status_reg[FCFC_S_ERR])
		else $error("invalid width code not flagged");
	irq_level_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
		##1 IRQ == |($past(status_reg & ~st_clr | st_set) & $past(mask_reg)))
		else $error("interrupt does not follow masked status");
endmodule : fcfc_top

// ===== rtl/fcfc_pkg.sv
// Constants, field layouts and state codes of the fax control frame codec.
package fcfc_pkg;
	// Bit clock of the control channel.
	localparam int FCFC_CLK_HZ = 250_000_000;
	localparam int FCFC_BIT_RATE_BPS = 300;
	localparam int FCFC_BIT_CYCLES = FCFC_CLK_HZ / FCFC_BIT_RATE_BPS;
	// Tone frequencies for the two bit values.
	localparam logic [10:0] FCFC_TONE_ZERO_HZ = 11'd1850;
	localparam logic [10:0] FCFC_TONE_ONE_HZ = 11'd1650;
	localparam logic [10:0] FCFC_TONE_OFF = 11'h000;
	// Frame sizes.
	localparam int FCFC_ID_BITS = 8;
	localparam int FCFC_CAP_BITS = 20;
	localparam int FCFC_FRAME_BITS = FCFC_ID_BITS + FCFC_CAP_BITS;
	localparam logic [4:0] FCFC_LEN_ID = 5'd8;
	localparam logic [4:0] FCFC_LEN_FULL = 5'd28;
	// Identification codes; the leading bit of the command code is a don't-care.
	localparam logic [7:0] FCFC_ID_DIS = 8'h01;
	localparam logic [7:0] FCFC_ID_DCS = 8'h41;
	localparam logic [7:0] FCFC_ID_DCS_MASK = 8'h7F;
	localparam logic [7:0] FCFC_ID_CFR = 8'h21;
	localparam logic [7:0] FCFC_ID_MCF = 8'h31;
	localparam logic [7:0] FCFC_ID_EOP = 8'h2F;
	localparam logic [7:0] FCFC_ID_DCN = 8'h5F;
	// Received frame kinds.
	localparam logic [2:0] FCFC_K_DIS = 3'h1;
	localparam logic [2:0] FCFC_K_DCS = 3'h2;
	localparam logic [2:0] FCFC_K_CFR = 3'h3;
	localparam logic [2:0] FCFC_K_MCF = 3'h4;
	localparam logic [2:0] FCFC_K_EOP = 3'h5;
	localparam logic [2:0] FCFC_K_DCN = 3'h6;
	// Field codes.
	localparam logic [1:0] FCFC_RATE_2400 = 2'h0;
	localparam logic [1:0] FCFC_RATE_4800 = 2'h1;
	localparam logic [1:0] FCFC_RATE_9600 = 2'h2;
	localparam logic [1:0] FCFC_W_1728 = 2'h0;
	localparam logic [1:0] FCFC_W_2432 = 2'h1;
	localparam logic [1:0] FCFC_W_2048 = 2'h2;
	localparam logic [1:0] FCFC_L_A4 = 2'h0;
	localparam logic [1:0] FCFC_L_UNL = 2'h1;
	localparam logic [1:0] FCFC_L_B4 = 2'h2;
	localparam logic [1:0] FCFC_CODE_BAD = 2'h3;
	// Appended field, bit 1 first on the line and at the top of the word.
	typedef struct packed {
		logic t2_tx;
		logic t2_rx;
		logic t2_ioc176;
		logic t3_tx;
		logic t3_rx;
		logic [2:0] t3_rsv;
		logic t4_tx;
		logic t4_rx;
		logic [1:0] rate;
		logic [1:0] mod_rsv;
		logic fine;
		logic twod;
		logic [1:0] width;
		logic [1:0] length;
	} fcfc_cap_t;
	// Register byte offsets.
	localparam logic [7:0] FCFC_A_CTRL = 8'h00;
	localparam logic [7:0] FCFC_A_LOCAL = 8'h04;
	localparam logic [7:0] FCFC_A_STATUS = 8'h08;
	localparam logic [7:0] FCFC_A_MASK = 8'h0C;
	localparam logic [7:0] FCFC_A_DIS = 8'h10;
	localparam logic [7:0] FCFC_A_DCS = 8'h14;
	localparam logic [7:0] FCFC_A_PHASE = 8'h18;
	// Control and status bit positions.
	localparam int FCFC_C_START = 0;
	localparam int FCFC_C_ANSWER = 1;
	localparam int FCFC_C_READY = 2;
	localparam int FCFC_S_RX = 0;
	localparam int FCFC_S_ERR = 1;
	localparam int FCFC_S_DONE = 2;
	localparam int FCFC_S_TCF = 3;
	localparam int FCFC_S_BITS = 4;
	localparam logic [1:0] FCFC_RESP_OK = 2'h0;
	localparam logic [1:0] FCFC_RESP_ERR = 2'h2;
	// Call phases, one-hot.
	typedef enum logic [14:0] {
		ST_IDLE = 15'h0001, ST_C_WAIT_DIS = 15'h0002, ST_C_SEND_DCS = 15'h0004,
		ST_C_TRAIN = 15'h0008, ST_C_WAIT_CFR = 15'h0010, ST_C_IMAGE = 15'h0020,
		ST_C_SEND_EOP = 15'h0040, ST_C_WAIT_MCF = 15'h0080, ST_C_SEND_DCN = 15'h0100,
		ST_A_SEND_DIS = 15'h0200, ST_A_WAIT_DCS = 15'h0400, ST_A_WAIT_TCF = 15'h0800,
		ST_A_SEND_CFR = 15'h1000, ST_A_WAIT_EOP = 15'h2000, ST_A_SEND_MCF = 15'h4000
	} fcfc_state_t;
endpackage : fcfc_pkg

// ===== rtl/fcfc_fsk_tx.sv
// Serialiser that keys a frame out as tones at the control bit rate.
`timescale 1ns/1ps
module fcfc_fsk_tx import fcfc_pkg::*; #(
	parameter int BIT_CYCLES = FCFC_BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [FCFC_FRAME_BITS-1:0] data,
	input wire logic [4:0] nbits,
	output logic [10:0] tone_hz,
	output logic active,
	output logic done
);
	localparam int TW = $clog2(BIT_CYCLES + 1);
	logic [FCFC_FRAME_BITS-1:0] sh_reg;
	logic [4:0] left_reg;
	logic [TW-1:0] tmr_reg;

	if (BIT_CYCLES < 2) begin : g_chk
		$error("fcfc_fsk_tx: BIT_CYCLES must be at least 2");
	end

	// A one is the lower tone, a zero the higher one.
	function automatic logic [10:0] fcfc_tone(input logic b);
		return b ? FCFC_TONE_ONE_HZ : FCFC_TONE_ZERO_HZ;
	endfunction : fcfc_tone

	// Each bit holds its tone for one whole bit period; the first bit leaves at the top.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg <= '0;
			left_reg <= '0;
			tmr_reg <= '0;
			active <= 1'b0;
			done <= 1'b0;
			tone_hz <= FCFC_TONE_OFF;
		end else begin
			done <= 1'b0;
			if (!active) begin
				if (load) begin
					sh_reg <= data;
					left_reg <= nbits;
					tmr_reg <= TW'(BIT_CYCLES - 1);
					active <= 1'b1;
					tone_hz <= fcfc_tone(data[FCFC_FRAME_BITS-1]);
				end
			end else if (tmr_reg != '0) begin
				tmr_reg <= tmr_reg - 1'b1;
			end else if (left_reg == 5'd1) begin
				active <= 1'b0;
				done <= 1'b1;
				tone_hz <= FCFC_TONE_OFF;
			end else begin
				sh_reg <= {sh_reg[FCFC_FRAME_BITS-2:0], 1'b0};
				left_reg <= left_reg - 1'b1;
				tmr_reg <= TW'(BIT_CYCLES - 1);
				tone_hz <= fcfc_tone(sh_reg[FCFC_FRAME_BITS-2]);
			end
		end
	end

	tone_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		active |-> (tone_hz == FCFC_TONE_ONE_HZ || tone_hz == FCFC_TONE_ZERO_HZ))
		else $error("tone outside the two keying frequencies");
endmodule : fcfc_fsk_tx

// ===== tb/fcfc_remote_model.sv
// Remote fax terminal model: keys frames into the parser and answers the local modem handshakes.
`timescale 1ns/1ps
module fcfc_remote_model import fcfc_pkg::*; (
	input wire logic clk,
	input wire logic train_req,
	input wire logic image_phase,
	output logic rx_bit,
	output logic rx_stb,
	output logic rx_end,
	output logic train_done,
	output logic image_done
);
	// Quiet lines at time zero.
	initial begin
		{rx_bit, rx_stb, rx_end, train_done, image_done} = 5'h00;
	end
	// Training and image finish one cycle after they are asked for; pulses so no request is counted twice.
	always @(posedge clk) begin
		train_done <= train_req && !train_done;
		image_done <= image_phase && !image_done;
	end
	// Sends n bits, the identification code first and its top bit leading, then ends the frame.
	task automatic send(input logic [27:0] f, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk);
			rx_bit <= f[i];
			rx_stb <= 1'b1;
			@(posedge clk);
			rx_stb <= 1'b0;
			rx_bit <= ~f[i]; // A released line must not keep showing the last bit.
		end
		@(posedge clk);
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
	endtask : send
endmodule : fcfc_remote_model

// ===== tb/fcfc_top_tb.sv
// Testbench for the codec: register map, a caller call, and answerer calls refused and accepted at TCF.
`timescale 1ns/1ps
module fcfc_top_tb import fcfc_pkg::*;;
	logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic tcf_stb = 1'b0, tcf_ok = 1'b0, awr, wrdy, bv, arr, rv, irq, act, tq, im, rb, rs, re, td, idn, cng, ced;
	logic ced_seen = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000, rdata, d;
	logic [1:0] bresp, rresp;
	logic [10:0] tone;
	fcfc_cap_t lc, dc, bad, ex;
	int n_fail = 0, tests_run = 0, k;
	// Four nanosecond core clock.
	always #2 clk = ~clk;
	// The answer tone lasts a single cycle, so it is caught in a sticky flag.
	always @(posedge clk) if (ced === 1'b1) ced_seen <= 1'b1;
	fcfc_top #(.BIT_CYCLES(4)) dut_u (.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.RX_BIT(rb), .RX_BIT_STB(rs), .RX_FRAME_END(re), .TRAIN_DONE(td), .TCF_STB(tcf_stb), .TCF_OK(tcf_ok),
		.IMAGE_DONE(idn), .TX_TONE_HZ(tone), .TX_ACTIVE(act), .TONE_CNG(cng), .TONE_CED(ced), .TRAIN_REQ(tq),
		.IMAGE_PHASE(im), .IRQ(irq));
	fcfc_remote_model rm_u (.clk(clk), .train_req(tq), .image_phase(im), .rx_bit(rb), .rx_stb(rs),
		.rx_end(re), .train_done(td), .image_done(idn));
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// One write; address and data are each released when taken, bready held until bvalid.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= v;
		{awv, wv, br} <= 3'b111;
		for (k = 0; k < 50 && bv !== 1'b1; k++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end
		br <= 1'b0;
		chk({31'h0, k < 50}, 32'h0000_0001);
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// One read; the data is taken at the edge that shows rvalid.
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		{arv, rr} <= 2'b11;
		for (k = 0; k < 50 && rv !== 1'b1; k++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end
		v = rdata;
		rr <= 1'b0;
		chk({31'h0, k < 50}, 32'h0000_0001);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// Polls the phase register until it shows p, with a bounded number of reads.
	task automatic wph(input logic [31:0] p);
		for (int j = 0; j < 300; j++) begin
			rd(FCFC_A_PHASE, d, FCFC_RESP_OK);
			if (d === p) break;
		end
		chk(d, p);
	endtask : wph
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		tally_and_finish;
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(FCFC_A_PHASE, d, FCFC_RESP_OK);
		chk(d, 32'h0000_0001);
		rd(8'h1C, d, FCFC_RESP_ERR);
		chk(d, 32'h0000_0000);
		wr(FCFC_A_DIS, 32'h0000_0001, FCFC_RESP_ERR);
		$display("test registers done");
		// Local limits both rates, widest width, unlimited; the remote offers V.29, 2048, B4 and fine resolution only.
		lc = '0;
		{lc.t4_tx, lc.t4_rx, lc.rate, lc.fine, lc.twod, lc.width, lc.length} = {4'hF, 2'h3, FCFC_W_2432, FCFC_L_UNL};
		dc = '0;
		{dc.t4_rx, dc.rate, dc.fine, dc.width, dc.length} = {1'b1, FCFC_RATE_9600, 1'b1, FCFC_W_2048, FCFC_L_B4};
		ex = dc;
		wr(FCFC_A_LOCAL, {12'h000, lc}, FCFC_RESP_OK);
		wr(FCFC_A_MASK, 32'h0000_0004, FCFC_RESP_OK);
		wr(FCFC_A_CTRL, 32'h0000_0001, FCFC_RESP_OK);
		wph(32'h0000_0002);
		chk({31'h0, cng}, 32'h0000_0001);
		chk({31'h0, ced_seen}, 32'h0000_0000);
		bad = dc;
		bad.width = FCFC_CODE_BAD;
		rm_u.send({FCFC_ID_DIS, bad}, 28);
		rd(FCFC_A_STATUS, d, FCFC_RESP_OK);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		wph(32'h0000_0002);
		rm_u.send({FCFC_ID_DIS, dc}, 28);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (act !== 1'b1 && k < 300);
		chk({21'h0, tone}, {21'h0, FCFC_TONE_ZERO_HZ});
		repeat (4) @(posedge clk);
		chk({21'h0, tone}, {21'h0, FCFC_TONE_ONE_HZ});
		rd(FCFC_A_DCS, d, FCFC_RESP_OK);
		chk(d, {12'h000, ex});
		rd(FCFC_A_DIS, d, FCFC_RESP_OK);
		chk(d, {12'h000, dc});
		wph(32'h0000_0010);
		rm_u.send({20'h0_0000, FCFC_ID_CFR}, 8);
		wph(32'h0000_0080);
		rm_u.send({20'h0_0000, FCFC_ID_MCF}, 8);
		wph(32'h0000_0001);
		rd(FCFC_A_STATUS, d, FCFC_RESP_OK);
		chk(d & 32'h0000_0004, 32'h0000_0004);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(FCFC_A_STATUS, 32'h0000_0004, FCFC_RESP_OK);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("test caller done");
		// Answerer without receive readiness must refuse at the training check.
		wr(FCFC_A_CTRL, 32'h0000_0003, FCFC_RESP_OK);
		wph(32'h0000_0400);
		chk({31'h0, ced_seen}, 32'h0000_0001);
		rm_u.send({FCFC_ID_DCS, ex}, 28);
		wph(32'h0000_0800);
		{tcf_ok, tcf_stb} <= 2'b11;
		@(posedge clk);
		tcf_stb <= 1'b0;
		wph(32'h0000_0001);
		rd(FCFC_A_STATUS, d, FCFC_RESP_OK);
		chk(d & 32'h0000_0008, 32'h0000_0008);
		$display("test answerer done");
		// Answerer ready for reception accepts the training check and completes the call.
		wr(FCFC_A_STATUS, 32'h0000_000F, FCFC_RESP_OK);
		wr(FCFC_A_CTRL, 32'h0000_0007, FCFC_RESP_OK);
		wph(32'h0000_0400);
		rm_u.send({FCFC_ID_DCS, ex}, 28);
		wph(32'h0000_0800);
		tcf_stb <= 1'b1;
		@(posedge clk);
		tcf_stb <= 1'b0;
		wph(32'h0000_2000);
		rm_u.send({20'h0_0000, FCFC_ID_EOP}, 8);
		wph(32'h0000_0001);
		rd(FCFC_A_STATUS, d, FCFC_RESP_OK);
		chk(d & 32'h0000_000C, 32'h0000_0004);
		chk({31'h0, irq}, 32'h0000_0001);
		// A disconnect heard while idle is a good frame that moves nothing.
		wr(FCFC_A_STATUS, 32'h0000_000F, FCFC_RESP_OK);
		rm_u.send({20'h0_0000, FCFC_ID_DCN}, 8);
		rd(FCFC_A_STATUS, d, FCFC_RESP_OK);
		chk(d & 32'h0000_0003, 32'h0000_0001);
		wph(32'h0000_0001);
		$display("test answerer accept done");
		tally_and_finish;
	end
endmodule : fcfc_top_tb
